// file: srr_read.sv
// Security register read command engine on the serial flash pins
// What this block does
// - Opcode and address bits are taken on each rising serial clock edge.
// - Data goes out MSB first, changing on falling serial clock edges.
// - After each byte the byte pointer steps by one to the next byte.
// - The pointer wraps from FFh to 00h inside the selected register only.
// - Chip select going high ends the read at any point.
// - The command is ignored while a busy cycle runs, leaving it untouched.
// - Address must be 00h, select 1 to 3, zero nibble, then a start byte.
// - The busy flag reads one for the whole self-timed cycle, else zero.
`timescale 1ns/1ps
`default_nettype none
module srr_read
  import srr_pkg::*;
#(
  parameter int DEPTH = SRR_FIFO_DEPTH
) (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, high
  input wire logic csN, // Chip select pin, low active
  input wire logic serialClk, // Serial clock pin from host
  input wire logic serial_in_pin, // Serial data in pin
  output logic serialOut, // Serial data out value
  output logic serialOutEnN, // Output enable, low drives pin
  input wire logic busyIn, // Self-timed cycle running
  output logic busyFlag, // Busy status bit
  output logic memReq, // Array read request pulse
  output logic [9:0] memAddr, // Select code and byte address
  input wire logic [7:0] memData, // Array read data
  input wire logic memValid // Array read data valid
);
  import srr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] csSync;
    logic [2:0] clkSync;
    logic [2:0] dinSync;
    logic csF;
    logic clkF;
    logic dinF;
    srr_phase_type phase;
    logic [4:0] bitCnt;
    logic [23:0] shiftIn;
    logic [1:0] regSel;
    logic [7:0] fetchPtr;
    logic [5:0] outst;
    logic [7:0] txShift;
    logic [2:0] txCnt;
    logic serialOut;
    logic outEnN;
    logic memReq;
    logic [9:0] memAddr;
    logic busyFlag;
  } srr_state_type;

  srr_state_type st_q, st_d;
  logic clkRise, clkFall, dinNow, fetching, popByte;
  logic [7:0] byteNow;
  logic [23:0] addrNow;
  logic addrOk;

  srr_fifo_if #(.W(SRR_BYTE_W), .DEPTH(DEPTH)) rdBuf ();

  srr_fifo #(.W(SRR_BYTE_W), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .port(rdBuf.store)
  );

  // Stale answers of an ended read are dropped, never buffered
  assign fetching = st_q.phase == SRR_DUMMY || st_q.phase == SRR_DATA;
  assign rdBuf.wrValid = memValid && fetching;
  assign rdBuf.wrData = memData;
  assign rdBuf.flush = !fetching;
  assign rdBuf.rdReady = popByte;

  assign serialOut = st_q.serialOut;
  assign serialOutEnN = st_q.outEnN;
  assign busyFlag = st_q.busyFlag;
  assign memReq = st_q.memReq;
  assign memAddr = st_q.memAddr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.memReq = 1'b0;
    popByte = 1'b0;
    st_d.busyFlag = busyIn;
    // Pins pass three stages; a change counts once stages two and three agree
    st_d.csSync = {st_q.csSync[1:0], csN};
    st_d.clkSync = {st_q.clkSync[1:0], serialClk};
    st_d.dinSync = {st_q.dinSync[1:0], serial_in_pin};
    if (st_q.csSync[1] == st_q.csSync[2]) st_d.csF = st_q.csSync[2];
    if (st_q.clkSync[1] == st_q.clkSync[2]) st_d.clkF = st_q.clkSync[2];
    if (st_q.dinSync[1] == st_q.dinSync[2]) st_d.dinF = st_q.dinSync[2];
    clkRise = st_d.clkF && !st_q.clkF;
    clkFall = !st_d.clkF && st_q.clkF;
    dinNow = st_d.dinF;
    byteNow = rdBuf.rdValid ? rdBuf.rdData : SRR_EMPTY_BYTE;
    addrNow = {st_q.shiftIn[22:0], dinNow};
    addrOk = addrNow[23:16] == SRR_ADDR_HIGH
      && addrNow[11:8] == SRR_ADDR_MID
      && addrNow[15:12] >= SRR_SEL_FIRST
      && addrNow[15:12] <= SRR_SEL_LAST;
    // In-order answers: one per request, counted until it returns
    st_d.outst = 6'(st_q.outst + st_q.memReq - memValid);

    if (st_d.csF) begin
      st_d.phase = SRR_IDLE;
      st_d.outEnN = 1'b1;
      st_d.bitCnt = '0;
    end else begin
      case (st_q.phase)
        SRR_IDLE: begin
          st_d.phase = SRR_OP;
          st_d.bitCnt = '0;
        end
        SRR_OP: begin
          if (clkRise) begin
            st_d.shiftIn = addrNow;
            st_d.bitCnt = 5'(st_q.bitCnt + 1'b1);
            if (st_q.bitCnt == SRR_OP_LAST) begin
              st_d.bitCnt = '0;
              // Busy cycle keeps running; the command just falls away
              if (addrNow[7:0] != SRR_OPCODE || busyIn) begin
                st_d.phase = SRR_IGNORE;
              end else begin
                st_d.phase = SRR_ADDR;
              end
            end
          end
        end
        SRR_ADDR: begin
          if (clkRise) begin
            st_d.shiftIn = addrNow;
            st_d.bitCnt = 5'(st_q.bitCnt + 1'b1);
            if (st_q.bitCnt == SRR_ADDR_LAST) begin
              st_d.bitCnt = '0;
              st_d.regSel = addrNow[13:12];
              st_d.fetchPtr = addrNow[7:0];
              st_d.phase = addrOk ? SRR_DUMMY : SRR_IGNORE;
            end
          end
        end
        SRR_DUMMY: begin
          if (clkRise) begin
            st_d.bitCnt = 5'(st_q.bitCnt + 1'b1);
            if (st_q.bitCnt == SRR_DUMMY_LAST) begin
              st_d.phase = SRR_DATA;
              st_d.txCnt = '0;
            end
          end
        end
        SRR_DATA: begin
          if (clkFall) begin
            st_d.outEnN = 1'b0;
            if (st_q.txCnt == '0) begin
              // Empty buffer means the host outran the array; ones go out
              popByte = 1'b1;
              st_d.serialOut = byteNow[7];
              st_d.txShift = {byteNow[6:0], 1'b0};
              st_d.txCnt = SRR_BITS_LAST;
            end else begin
              st_d.serialOut = st_q.txShift[7];
              st_d.txShift = {st_q.txShift[6:0], 1'b0};
              st_d.txCnt = 3'(st_q.txCnt - 1'b1);
            end
          end
        end
        SRR_IGNORE: begin
          st_d.outEnN = 1'b1;
        end
        default: begin
          st_d.phase = SRR_IDLE;
        end
      endcase
    end

    // Read-ahead, limited by the room left in the buffer
    if (fetching && st_d.phase != SRR_IDLE && rdBuf.wrReady
        && 7'(st_q.outst + st_q.memReq + rdBuf.level) < 7'(DEPTH)) begin
      st_d.memReq = 1'b1;
      st_d.memAddr = {st_q.regSel, st_q.fetchPtr};
      st_d.fetchPtr = 8'(st_q.fetchPtr + 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
      st_q.csSync <= SRR_SYNC_RST;
      st_q.csF <= 1'b1;
      st_q.outEnN <= 1'b1;
      st_q.phase <= SRR_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hiz;
    @(posedge mclk) disable iff (reset)
      st_q.csF || st_q.phase inside {SRR_OP, SRR_ADDR, SRR_DUMMY}
      |-> st_q.outEnN;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("Output driven outside data phase");

  property p_end;
    @(posedge mclk) disable iff (reset)
      st_d.csF |=> st_q.phase == SRR_IDLE ##1 !st_q.memReq;
  endproperty
  a_end: assert property (p_end)
    else $error("Read not ended by chip select");

  // Both edges of the busy cycle must show on the flag, one cycle later
  property p_busy;
    @(posedge mclk) disable iff (reset)
      1'b1 |=> busyFlag == $past(busyIn);
  endproperty
  a_busy: assert property (p_busy)
    else $error("Busy flag does not follow busy cycle");

  property p_ignore;
    @(posedge mclk) disable iff (reset)
      st_q.phase == SRR_OP && clkRise && st_q.bitCnt == SRR_OP_LAST
      && busyIn && !st_d.csF
      |=> st_q.phase == SRR_IGNORE && st_q.outEnN && !st_q.memReq;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("Command taken while busy");

  property p_addr;
    @(posedge mclk) disable iff (reset)
      st_q.phase == SRR_ADDR && clkRise && st_q.bitCnt == SRR_ADDR_LAST
      && !addrOk && !st_d.csF |=> st_q.phase == SRR_IGNORE;
  endproperty
  a_addr: assert property (p_addr)
    else $error("Bad address accepted");

  property p_sample;
    @(posedge mclk) disable iff (reset)
      st_q.phase inside {SRR_OP, SRR_ADDR} && clkRise && !st_d.csF
      |=> st_q.shiftIn[0] == $past(dinNow);
  endproperty
  a_sample: assert property (p_sample)
    else $error("Input bit not taken on rising edge");

  property p_msb;
    @(posedge mclk) disable iff (reset)
      st_q.phase == SRR_DATA && clkFall && st_q.txCnt == '0 && !st_d.csF
      |-> popByte ##1 (!st_q.outEnN && st_q.serialOut == $past(byteNow[7])
      && st_q.txCnt == SRR_BITS_LAST);
  endproperty
  a_msb: assert property (p_msb)
    else $error("Byte not started MSB first");

  property p_wrap;
    @(posedge mclk) disable iff (reset)
      st_q.memReq |-> st_q.memAddr[9:8] == st_q.regSel
      && st_q.fetchPtr == 8'(st_q.memAddr[7:0] + 1'b1);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Pointer left register or skipped");
endmodule : srr_read
`default_nettype wire

// file: srr_pkg.sv
// Constants and types for the security register read path
`default_nettype none
package srr_pkg;
  localparam logic [7:0] SRR_OPCODE = 8'h48;
  localparam logic [4:0] SRR_OP_LAST = 5'h07;
  localparam logic [4:0] SRR_ADDR_LAST = 5'h17;
  localparam logic [4:0] SRR_DUMMY_LAST = 5'h07;
  localparam logic [7:0] SRR_ADDR_HIGH = 8'h00;
  localparam logic [3:0] SRR_ADDR_MID = 4'h0;
  localparam logic [3:0] SRR_SEL_FIRST = 4'h1;
  localparam logic [3:0] SRR_SEL_LAST = 4'h3;
  localparam int SRR_BYTE_W = 8;
  localparam int SRR_FIFO_DEPTH = 16;
  localparam logic [2:0] SRR_SYNC_RST = 3'h7;
  localparam logic [2:0] SRR_BITS_LAST = 3'h7;
  localparam logic [7:0] SRR_EMPTY_BYTE = 8'hff;

  typedef enum logic [2:0] {
    SRR_IDLE = 3'b000,
    SRR_OP = 3'b001,
    SRR_ADDR = 3'b010,
    SRR_DUMMY = 3'b011,
    SRR_DATA = 3'b100,
    SRR_IGNORE = 3'b101
  } srr_phase_type;
endpackage : srr_pkg
`default_nettype wire

// file: srr_fifo_if.sv
// Interface between the command engine and its read-ahead FIFO
`timescale 1ns/1ps
`default_nettype none
interface srr_fifo_if #(
  parameter int W = 8,
  parameter int DEPTH = 16
);
  logic wrValid;
  logic wrReady;
  logic [W-1:0] wrData;
  logic rdValid;
  logic rdReady;
  logic [W-1:0] rdData;
  logic flush;
  logic [$clog2(DEPTH):0] level;

  modport store (
    input wrValid, wrData, rdReady, flush,
    output wrReady, rdValid, rdData, level
  );
  modport user (
    output wrValid, wrData, rdReady, flush,
    input wrReady, rdValid, rdData, level
  );
endinterface : srr_fifo_if
`default_nettype wire

// file: srr_fifo.sv
// Synchronous FIFO with flush, built from flip-flops
`timescale 1ns/1ps
`default_nettype none
module srr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk, // System clock
  input wire logic reset, // Synchronous reset, high
  srr_fifo_if.store port // Fill and drain sides
);
  import srr_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } srr_fifo_state_type;

  srr_fifo_state_type st_q, st_d;
  logic doWr, doRd;

  assign port.wrReady = st_q.count != FULL;
  assign port.rdValid = st_q.count != '0;
  assign port.rdData = st_q.mem[st_q.rdPtr];
  assign port.level = st_q.count;

  always_comb begin
    st_d = st_q;
    doWr = port.wrValid && port.wrReady;
    doRd = port.rdReady && port.rdValid;
    if (port.flush) begin
      st_d.wrPtr = '0;
      st_d.rdPtr = '0;
      st_d.count = '0;
    end else begin
      if (doWr) begin
        st_d.mem[st_q.wrPtr] = port.wrData;
        st_d.wrPtr = AW'(st_q.wrPtr + 1'b1);
      end
      if (doRd) begin
        st_d.rdPtr = AW'(st_q.rdPtr + 1'b1);
      end
      st_d.count = (AW+1)'(st_q.count + doWr - doRd);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : srr_fifo
`default_nettype wire

// file: srr_host_model.sv
// Serial host controller model driving the security register read frames
`timescale 1ns/1ps
`default_nettype none
module srr_host_model (
  input wire logic mclk, // System clock
  output logic csN, // Chip select, low active
  output logic serialClk, // Serial clock, idle low
  output logic serialIn, // Command bits to device
  input wire logic serialOut, // Device data
  input wire logic serialOutEnN // Device enable, low drives
);
  logic [7:0] rx[$];
  logic [7:0] sh;
  int cmdEn;
  int dataEn;

  initial begin
    csN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  // Six mclk per half period keeps the device's filter margin
  task automatic bitx(input logic b, input logic dat);
    serialIn <= b;
    wt(6);
    if (serialOutEnN === 1'b0) begin
      if (dat) dataEn++;
      else cmdEn++;
    end
    if (dat) sh = {sh[6:0], (serialOutEnN === 1'b0) ? serialOut : 1'bx};
    serialClk <= 1'b1;
    wt(6);
    serialClk <= 1'b0;
  endtask : bitx

  task automatic frame(input logic [7:0] op, input logic [23:0] a,
                       input int nb);
    logic [39:0] cmd;
    cmd = {op, a, 8'h55};
    rx.delete();
    cmdEn = 0;
    dataEn = 0;
    csN <= 1'b0;
    for (int i = 39; i >= 0; i--) bitx(cmd[i], 1'b0);
    for (int i = 0; i < nb; i++) begin
      bitx(i[0], 1'b1);
      if (i % 8 == 7) rx.push_back(sh);
    end
    wt(6);
    csN <= 1'b1;
    serialIn <= ~serialIn;
    wt(10);
  endtask : frame
endmodule : srr_host_model
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the security register read path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import srr_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic busyIn = 1'b0;
  logic [7:0] memData = 8'h00;
  logic memValid = 1'b0;
  logic v1 = 1'b0;
  logic csN, serialClk, serial_in_pin, serialOut, serialOutEnN;
  logic busyFlag, memReq;
  logic [9:0] memAddr, a1;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int reqs = 0;

  always #5 mclk = ~mclk;

  srr_read #(.DEPTH(SRR_FIFO_DEPTH)) DUT (.mclk(mclk), .reset(reset),
    .csN(csN), .serialClk(serialClk), .serial_in_pin(serial_in_pin),
    .serialOut(serialOut), .serialOutEnN(serialOutEnN), .busyIn(busyIn),
    .busyFlag(busyFlag), .memReq(memReq), .memAddr(memAddr),
    .memData(memData), .memValid(memValid));

  srr_host_model HOST (.mclk(mclk), .csN(csN), .serialClk(serialClk),
    .serialIn(serial_in_pin), .serialOut(serialOut),
    .serialOutEnN(serialOutEnN));

  // ----------------------------------------
  // Array stand-in, two cycles of latency
  // ----------------------------------------
  function automatic logic [7:0] pat(input logic [9:0] a);
    return a[7:0] ^ {a[9:8], 6'h15};
  endfunction : pat

  always @(posedge mclk) begin
    v1 <= memReq;
    a1 <= memAddr;
    memValid <= v1;
    memData <= pat(a1);
    if (memReq === 1'b1) reqs++;
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int s = 1; s <= 3; s++) begin
      HOST.frame(SRR_OPCODE, {SRR_ADDR_HIGH, 4'(s), SRR_ADDR_MID, 8'hff}, 24);
      check(HOST.rx.size(), 3);
      for (int i = 0; i < 3; i++)
        check(HOST.rx[i], pat({2'(s), 8'(8'hff + i)}));
      check(HOST.cmdEn, 0);
      check(HOST.dataEn, 24);
      check(serialOutEnN, 1);
    end
  endtask : t_regs

  // Cut mid-byte, then a fresh frame must not see leftover bytes
  task automatic t_stop;
    HOST.frame(SRR_OPCODE, 24'h003040, 13);
    check(HOST.rx.size(), 1);
    check(HOST.rx[0], pat(10'h340));
    check(serialOutEnN, 1);
    HOST.frame(SRR_OPCODE, 24'h001000, 8);
    check(HOST.rx[0], pat(10'h100));
  endtask : t_stop

  task automatic t_refuse;
    logic [31:0] bad [5] = '{32'h0b001000, 32'h48011000, 32'h48001100,
                             32'h48000000, 32'h48004000};
    for (int i = 0; i < 5; i++) begin
      reqs = 0;
      HOST.frame(bad[i][31:24], bad[i][23:0], 16);
      check(reqs, 0);
      check(HOST.dataEn + HOST.cmdEn, 0);
    end
  endtask : t_refuse

  task automatic t_busy;
    busyIn <= 1'b1;
    HOST.wt(2);
    check(busyFlag, 1);
    reqs = 0;
    HOST.frame(SRR_OPCODE, 24'h002000, 16);
    check(reqs, 0);
    check(HOST.dataEn, 0);
    check(busyFlag, 1);
    busyIn <= 1'b0;
    HOST.wt(2);
    check(busyFlag, 0);
    HOST.frame(SRR_OPCODE, 24'h002000, 8);
    check(HOST.rx[0], pat(10'h200));
  endtask : t_busy

  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    check(serialOutEnN, 1);
    t_regs();
    t_stop();
    t_refuse();
    t_busy();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
